// ### common/hot_swap_pkg.sv
// Constants, types and timing tables for the hot-swap sequencer
package hot_swap_pkg;
    // APB byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CFG_W = 24;
    localparam logic [23:0] CONFIG_RESET = 24'h100834;
    // Field positions in the config word
    localparam int F_STAGE = 0;
    localparam int F_TRIP = 3;
    localparam int F_FAST = 5;
    localparam int F_COOL = 7;
    localparam int F_REG_EN = 8;
    localparam int F_REG_WIN = 9;
    localparam int F_UV_HYST = 11;
    localparam int F_SUPPLY = 15;
    localparam int F_SFILT = 17;
    localparam int F_SEAT = 19;
    localparam int F_SEC = 21;
    localparam int F_FUSE = 23;
    // Field encodings
    localparam logic [1:0] SUPPLY_FILTER = 2'h1;
    localparam logic [1:0] SUPPLY_LATCH = 2'h2;
    localparam logic [1:0] SEC_SHUTDOWN = 2'h0;
    localparam logic [1:0] SEC_GATE_PG1 = 2'h1;
    localparam logic [1:0] SEC_PG1_LEADS = 2'h2;
    localparam logic [1:0] FAST_200 = 2'h0;
    localparam logic [1:0] FAST_100 = 2'h1;
    localparam logic [1:0] FAST_60 = 2'h2;
    localparam logic [1:0] STEP_LAST = 2'h3;
    localparam logic [9:0] STATUS_W = 10'h00a;
    // Time base: all delays count whole microseconds
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLOCK_PERIOD_NS;
    localparam int HOLDOFF_US = 100000;
    typedef logic [22:0] time_us_t;
    localparam time_us_t STAGE_US [8] = '{23'd50, 23'd250, 23'd500, 23'd1500,
        23'd5000, 23'd20000, 23'd80000, 23'd160000};
    localparam time_us_t TRIP_US [4] = '{23'd400, 23'd150, 23'd50, 23'd5};
    localparam time_us_t REG_WIN_US [4] = '{23'd5000, 23'd80000, 23'd320000, 23'd320000};
    localparam time_us_t SEAT_US [4] = '{23'd500, 23'd5000, 23'd80000, 23'd160000};
    localparam time_us_t SFILT_US [4] = '{23'd5000, 23'd80000, 23'd160000, 23'd160000};
    localparam time_us_t COOL_US [2] = '{23'd2500000, 23'd5000000};
    // Bit positions in the synchronised input vector
    localparam int IN_SEAT1 = 0;
    localparam int IN_SEAT2 = 1;
    localparam int IN_ENABLE = 2;
    localparam int IN_LOW_SUP = 3;
    localparam int IN_HIGH_SUP = 4;
    localparam int IN_DRAIN = 5;
    localparam int IN_GATE = 6;
    localparam int IN_S50 = 7;
    localparam int IN_S60 = 8;
    localparam int IN_S100 = 9;
    localparam int IN_S200 = 10;
    localparam int IN_SEC = 11;
    localparam int IN_LA = 12;
    localparam int IN_LB = 13;
    localparam int IN_LC = 14;
    localparam int IN_MODE = 15;
    localparam int IN_CLEAR = 16;
    localparam int IN_FUSE = 17;
    localparam int IN_W = 18;
    typedef enum logic [2:0] {ST_IDLE, ST_RAMP, ST_RUN, ST_COOL, ST_LATCH} seq_state_t;
endpackage : hot_swap_pkg

// ### hdl/sync_bits.sv
// Two-flop synchroniser for a vector of independent level inputs
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sync_bits

// ### hdl/hot_swap_sequence_fault_logic.sv
// Hot-swap sequencing, power-good cascade and fault handling with APB config
// Behaviour
// - Latched supply fault: outputs stay off, fault on
// - Undervoltage hysteresis programmable in 62.5mV steps
// - Power-good needs drain low and gate full
// - Gate-full indication latched once seen
// - Drain monitored while running except while regulating
// - Stage one first, then one delay each
// - Eight selectable stage delays, default 5ms
// - Load enables A/B/C disable later stages
// - Ignore secondary shutdown until holdoff expires
// - Low secondary shutdown after holdoff faults
// - Secondary input optionally enables stage one
// - Breaker trips after filtered 50mV overcurrent
// - Trip filter 5/50/150/400us, default 50us
// - Fast trip unfiltered at selectable level
// - Retry cooling 2.5s or 5s
// - Optional regulation above 50mV below fast level
// - Regulation window expiry shuts down at once
// - Dropping below 50mV clears regulation window
// - Fast trip during regulation bypasses window
// - Optional persistent fuse set by every trip
// - Fuse keeps fault on, power path off
// - Breaker trip: gate off, fault asserted
// - Mode pin: retry after cooling or latch
// - Both seats low for qualify delay first
// - Unfiltered supply fault shuts down immediately
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module hot_swap_sequence_fault_logic #(
    parameter int US_CYCLES = hot_swap_pkg::US_CYCLES,
    parameter int HOLDOFF_US = hot_swap_pkg::HOLDOFF_US
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_seat_1_n,
    input wire logic card_seat_2_n,
    input wire logic master_enable_thermal,
    input wire logic low_supply_compare,
    input wire logic high_supply_compare,
    input wire logic drain_above_ref,
    input wire logic gate_at_margin,
    input wire logic shunt_over_50,
    input wire logic shunt_over_60,
    input wire logic shunt_over_100,
    input wire logic shunt_over_200,
    input wire logic secondary_shutdown_n,
    input wire logic load_enable_a,
    input wire logic load_enable_b,
    input wire logic load_enable_c,
    input wire logic breaker_mode,
    input wire logic breaker_clear_n,
    input wire logic fuse_stored,
    output logic fet_gate_drive,
    output logic gate_regulate,
    output logic power_good_stage1_n,
    output logic power_good_stage2_n,
    output logic power_good_stage3_n,
    output logic power_good_stage4_n,
    output logic fault_n,
    output logic sticky_breaker_fuse,
    output logic [3:0] uv_hysteresis_steps
);
    typedef hot_swap_pkg::time_us_t tus_t;
    logic [hot_swap_pkg::IN_W-1:0] rawIn;
    logic [hot_swap_pkg::IN_W-1:0] s;
    logic [hot_swap_pkg::CFG_W-1:0] cfg;
    hot_swap_pkg::seq_state_t state;
    hot_swap_pkg::seq_state_t next_state;
    logic [7:0] prescale;
    logic usTick;
    tus_t stateCnt;
    tus_t filtCnt;
    tus_t regCnt;
    tus_t supCnt;
    tus_t holdCnt;
    tus_t stageCnt;
    logic [1:0] stageStep;
    logic [1:0] loadWait;
    logic gateLatched;
    logic clearSeen;
    logic active;
    logic seatOk;
    logic runOk;
    logic supplyBad;
    logic secOk;
    logic fastHit;
    logic regulating;
    logic filterTrip;
    logic regExpired;
    logic trip;
    logic supplyDown;
    logic holdExpired;
    logic secFault;
    logic drainFault;
    logic qualified;
    logic allow1;
    logic runNext;
    logic cfgWrite;
    logic [9:0] status;

    // Strictly greater, so a delay is never shorter than printed
    function automatic logic elapsed(input tus_t cnt, input tus_t lim);
        return cnt > lim;
    endfunction : elapsed

    // Microsecond counter step that saturates instead of wrapping
    function automatic tus_t bump(input tus_t cnt, input logic tick);
        return (tick && (cnt != '1)) ? tus_t'(cnt + 23'h000001) : cnt;
    endfunction : bump

    // Every pin and comparator result is resynchronised
    assign rawIn = {fuse_stored, breaker_clear_n, breaker_mode, load_enable_c,
        load_enable_b, load_enable_a, secondary_shutdown_n, shunt_over_200,
        shunt_over_100, shunt_over_60, shunt_over_50, gate_at_margin,
        drain_above_ref, high_supply_compare, low_supply_compare,
        master_enable_thermal, card_seat_2_n, card_seat_1_n};

    sync_bits #(.WIDTH(hot_swap_pkg::IN_W)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(rawIn),
        .sync_out(s)
    );

    // Condition decode
    assign active = (state == hot_swap_pkg::ST_RAMP) || (state == hot_swap_pkg::ST_RUN);
    assign seatOk = !s[hot_swap_pkg::IN_SEAT1] && !s[hot_swap_pkg::IN_SEAT2];
    assign runOk = seatOk && s[hot_swap_pkg::IN_ENABLE];
    assign supplyBad = s[hot_swap_pkg::IN_LOW_SUP] || s[hot_swap_pkg::IN_HIGH_SUP];
    assign secOk = s[hot_swap_pkg::IN_SEC];
    assign usTick = (prescale == 8'(US_CYCLES - 1));

    // Fast trip level select
    always_comb begin
        case (cfg[hot_swap_pkg::F_FAST +: 2])
            hot_swap_pkg::FAST_200: fastHit = s[hot_swap_pkg::IN_S200];
            hot_swap_pkg::FAST_100: fastHit = s[hot_swap_pkg::IN_S100];
            hot_swap_pkg::FAST_60: fastHit = s[hot_swap_pkg::IN_S60];
            default: fastHit = 1'b0;
        endcase
    end

    // Regulation replaces the trip filter when it is enabled
    assign regulating = cfg[hot_swap_pkg::F_REG_EN] && active && s[hot_swap_pkg::IN_S50]
        && !fastHit;
    assign filterTrip = !cfg[hot_swap_pkg::F_REG_EN]
        && elapsed(filtCnt, hot_swap_pkg::TRIP_US[cfg[hot_swap_pkg::F_TRIP +: 2]]);
    assign regExpired = regulating
        && elapsed(regCnt, hot_swap_pkg::REG_WIN_US[cfg[hot_swap_pkg::F_REG_WIN +: 2]]);
    assign trip = active && (fastHit || filterTrip || regExpired);
    assign holdExpired = elapsed(holdCnt, tus_t'(HOLDOFF_US));
    assign secFault = (cfg[hot_swap_pkg::F_SEC +: 2] == hot_swap_pkg::SEC_SHUTDOWN)
        && holdExpired && !secOk;
    assign drainFault = (state == hot_swap_pkg::ST_RUN) && s[hot_swap_pkg::IN_DRAIN]
        && !regulating;
    assign qualified = runOk && !supplyBad
        && elapsed(stateCnt, hot_swap_pkg::SEAT_US[cfg[hot_swap_pkg::F_SEAT +: 2]]);

    // Supply fault handling mode
    always_comb begin
        case (cfg[hot_swap_pkg::F_SUPPLY +: 2])
            hot_swap_pkg::SUPPLY_FILTER:
                supplyDown = elapsed(supCnt, hot_swap_pkg::SFILT_US[cfg[hot_swap_pkg::F_SFILT +: 2]]);
            hot_swap_pkg::SUPPLY_LATCH: supplyDown = 1'b0;
            default: supplyDown = supplyBad;
        endcase
    end

    // Sequencer next state; faults are ranked fuse, trip, latch, shutdown
    always_comb begin
        next_state = state;
        case (state)
            hot_swap_pkg::ST_IDLE: begin
                if (sticky_breaker_fuse) begin
                    next_state = hot_swap_pkg::ST_LATCH;
                end else if (qualified) begin
                    next_state = hot_swap_pkg::ST_RAMP;
                end
            end
            hot_swap_pkg::ST_RAMP, hot_swap_pkg::ST_RUN: begin
                if (sticky_breaker_fuse) begin
                    next_state = hot_swap_pkg::ST_LATCH;
                end else if (trip) begin
                    next_state = s[hot_swap_pkg::IN_MODE] ? hot_swap_pkg::ST_COOL
                        : hot_swap_pkg::ST_LATCH;
                end else if (supplyBad && (cfg[hot_swap_pkg::F_SUPPLY +: 2]
                        == hot_swap_pkg::SUPPLY_LATCH)) begin
                    next_state = hot_swap_pkg::ST_LATCH;
                end else if (secFault) begin
                    next_state = hot_swap_pkg::ST_LATCH;
                end else if (!runOk || supplyDown || drainFault) begin
                    next_state = hot_swap_pkg::ST_IDLE;
                end else if (state == hot_swap_pkg::ST_RAMP && gateLatched
                        && !s[hot_swap_pkg::IN_DRAIN]) begin
                    next_state = hot_swap_pkg::ST_RUN;
                end
            end
            hot_swap_pkg::ST_COOL: begin
                if (sticky_breaker_fuse) begin
                    next_state = hot_swap_pkg::ST_LATCH;
                end else if (elapsed(stateCnt, hot_swap_pkg::COOL_US[cfg[hot_swap_pkg::F_COOL]])) begin
                    next_state = hot_swap_pkg::ST_IDLE;
                end
            end
            hot_swap_pkg::ST_LATCH: begin
                if (clearSeen && s[hot_swap_pkg::IN_CLEAR] && !sticky_breaker_fuse) begin
                    next_state = hot_swap_pkg::ST_IDLE;
                end
            end
            default: next_state = hot_swap_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= hot_swap_pkg::ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Microsecond prescaler shared by all timers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 8'h00;
        end else if (ce) begin
            prescale <= usTick ? 8'h00 : 8'(prescale + 8'h01);
        end
    end

    // Per-state timer; in idle it restarts whenever a condition drops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateCnt <= '0;
        end else if (ce) begin
            if (next_state != state || (state == hot_swap_pkg::ST_IDLE && !(runOk && !supplyBad))) begin
                stateCnt <= '0;
            end else begin
                stateCnt <= bump(stateCnt, usTick);
            end
        end
    end

    // Overcurrent, regulation, supply filter and holdoff timers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filtCnt <= '0;
            regCnt <= '0;
            supCnt <= '0;
            holdCnt <= '0;
        end else if (ce) begin
            filtCnt <= (active && s[hot_swap_pkg::IN_S50]) ? bump(filtCnt, usTick) : '0;
            regCnt <= regulating ? bump(regCnt, usTick) : '0;
            supCnt <= (active && supplyBad) ? bump(supCnt, usTick) : '0;
            holdCnt <= active ? bump(holdCnt, usTick) : '0;
        end
    end

    // Power-good cascade: one stage delay per step once running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stageCnt <= '0;
            stageStep <= 2'h0;
        end else if (ce) begin
            if (state != hot_swap_pkg::ST_RUN) begin
                stageCnt <= '0;
                stageStep <= 2'h0;
            end else if (stageStep != hot_swap_pkg::STEP_LAST
                    && elapsed(stageCnt, hot_swap_pkg::STAGE_US[cfg[hot_swap_pkg::F_STAGE +: 3]])) begin
                stageCnt <= '0;
                stageStep <= 2'(stageStep + 2'h1);
            end else begin
                stageCnt <= bump(stageCnt, usTick);
            end
        end
    end

    // Gate-full seen once stays latched for the whole power-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gateLatched <= 1'b0;
        end else if (ce) begin
            if (!active) begin
                gateLatched <= 1'b0;
            end else if (s[hot_swap_pkg::IN_GATE]) begin
                gateLatched <= 1'b1;
            end
        end
    end

    // Clear pulse must go low and come back high while latched
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clearSeen <= 1'b0;
        end else if (ce) begin
            if (state != hot_swap_pkg::ST_LATCH) begin
                clearSeen <= 1'b0;
            end else if (!s[hot_swap_pkg::IN_CLEAR]) begin
                clearSeen <= 1'b1;
            end
        end
    end

    // Fuse: restored once from the stored cell after reset; set beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loadWait <= 2'h0;
            sticky_breaker_fuse <= 1'b0;
        end else if (ce) begin
            if (loadWait != 2'h3) begin
                loadWait <= 2'(loadWait + 2'h1);
            end
            if (trip && cfg[hot_swap_pkg::F_FUSE]) begin
                sticky_breaker_fuse <= 1'b1;
            end else if (loadWait == 2'h2 && s[hot_swap_pkg::IN_FUSE]) begin
                sticky_breaker_fuse <= 1'b1;
            end else if (cfgWrite) begin
                sticky_breaker_fuse <= 1'b0;
            end
        end
    end

    // Stage enables from the load and secondary inputs
    assign runNext = (next_state == hot_swap_pkg::ST_RUN);
    assign allow1 = (cfg[hot_swap_pkg::F_SEC +: 2] == hot_swap_pkg::SEC_SHUTDOWN) || secOk;

    // Outputs follow the next state so gate and stages drop together
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fet_gate_drive <= 1'b0;
            gate_regulate <= 1'b0;
            power_good_stage1_n <= 1'b1;
            power_good_stage2_n <= 1'b1;
            power_good_stage3_n <= 1'b1;
            power_good_stage4_n <= 1'b1;
            fault_n <= 1'b1;
            uv_hysteresis_steps <= 4'h0;
        end else if (ce) begin
            fet_gate_drive <= (next_state == hot_swap_pkg::ST_RAMP) || runNext;
            gate_regulate <= regulating && (next_state == state);
            power_good_stage1_n <= !(runNext && allow1);
            power_good_stage2_n <= !(runNext && stageStep >= 2'h1 && s[hot_swap_pkg::IN_LA]
                && (allow1 || cfg[hot_swap_pkg::F_SEC +: 2] != hot_swap_pkg::SEC_PG1_LEADS));
            power_good_stage3_n <= !(runNext && stageStep >= 2'h2 && s[hot_swap_pkg::IN_LA]
                && s[hot_swap_pkg::IN_LB]
                && (allow1 || cfg[hot_swap_pkg::F_SEC +: 2] != hot_swap_pkg::SEC_PG1_LEADS));
            power_good_stage4_n <= !(runNext && stageStep == 2'h3 && s[hot_swap_pkg::IN_LA]
                && s[hot_swap_pkg::IN_LB] && s[hot_swap_pkg::IN_LC]
                && (allow1 || cfg[hot_swap_pkg::F_SEC +: 2] != hot_swap_pkg::SEC_PG1_LEADS));
            fault_n <= !((next_state == hot_swap_pkg::ST_COOL)
                || (next_state == hot_swap_pkg::ST_LATCH));
            uv_hysteresis_steps <= cfg[hot_swap_pkg::F_UV_HYST +: 4];
        end
    end

    // APB: write lands at the edge where pready is sampled high
    assign cfgWrite = psel && penable && pready && pwrite && (paddr == hot_swap_pkg::ADDR_CONFIG);
    assign status = {clearSeen, sticky_breaker_fuse, gateLatched, regulating, holdExpired,
        stageStep, state};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= hot_swap_pkg::CONFIG_RESET;
        end else if (ce && cfgWrite) begin
            cfg <= pwdata[hot_swap_pkg::CFG_W-1:0];
        end
    end

    // One wait state; unmapped addresses answer with pslverr
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (paddr != hot_swap_pkg::ADDR_CONFIG)
                && (paddr != hot_swap_pkg::ADDR_STATUS);
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    hot_swap_pkg::ADDR_CONFIG: prdata <= {8'h00, cfg};
                    hot_swap_pkg::ADDR_STATUS: prdata <= {22'h000000, status};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_start;
        (state == hot_swap_pkg::ST_IDLE) ##1 (state == hot_swap_pkg::ST_RAMP);
    endsequence

    sequence s_fast;
        ce && active && fastHit;
    endsequence

    a_latch_holds_off: assert property ((state == hot_swap_pkg::ST_LATCH)
        |-> !fet_gate_drive && !fault_n && power_good_stage1_n)
        else $error("Latched state left power path on");
    a_pg_needs_gate: assert property (!power_good_stage1_n
        |-> gateLatched && state == hot_swap_pkg::ST_RUN)
        else $error("Stage one on without gate latch");
    a_gate_latch_sticky: assert property ((gateLatched && active && !$fell(active))
        |=> gateLatched || !active)
        else $error("Gate latch dropped while powered");
    a_load_cascade: assert property (!power_good_stage3_n
        |-> $past(s[hot_swap_pkg::IN_LA]) && $past(s[hot_swap_pkg::IN_LB]) && stageStep >= 2'h2)
        else $error("Stage three on while disabled");
    a_fast_trip: assert property (s_fast
        |=> (state == hot_swap_pkg::ST_COOL || state == hot_swap_pkg::ST_LATCH) && !fet_gate_drive)
        else $error("Fast trip did not shut down");
    a_shutdown_fault: assert property ((ce && active && secFault && !trip && !sticky_breaker_fuse)
        |=> state == hot_swap_pkg::ST_LATCH && !fault_n)
        else $error("Secondary shutdown not faulted");
    a_fuse_blocks: assert property (sticky_breaker_fuse |-> !fet_gate_drive)
        else $error("Fuse set with gate driven");
    a_reg_expiry: assert property ((ce && regExpired && !sticky_breaker_fuse)
        |=> !fet_gate_drive && !fault_n)
        else $error("Regulation window expiry ignored");
    a_seat_qualify: assert property (s_start |-> $past(stateCnt, 1)
        > hot_swap_pkg::SEAT_US[cfg[hot_swap_pkg::F_SEAT +: 2]])
        else $error("Power-up before seat qualify delay");
    a_reg_drive: assert property (gate_regulate |-> fet_gate_drive)
        else $error("Regulating without gate drive");
endmodule : hot_swap_sequence_fault_logic

// ### tb/hot_swap_far_side.sv
// Far-side model: power FET gate and secondary supervisor
`timescale 1ns/1ps
module hot_swap_far_side (
    input wire logic core_clk,
    input wire logic fet_gate_drive,
    output logic gate_at_margin,
    output logic drain_above_ref,
    output logic secondary_shutdown_n
);
    logic [5:0] ramp = 6'h00;
    // Gate charges slowly but discharges at once
    always @(posedge core_clk) begin
        ramp <= fet_gate_drive ? ramp + {5'h00, ramp != 6'h3f} : 6'h00;
    end
    assign gate_at_margin = ramp > 6'h08;
    assign drain_above_ref = ramp < 6'h0c;
    // Unpowered secondary holds low; rises well inside holdoff
    assign secondary_shutdown_n = ramp > 6'h14;
endmodule : hot_swap_far_side

// ### tb/hot_swap_sequence_fault_logic_tb.sv
// Self-checking bench for the hot-swap sequencer
`timescale 1ns/1ps
module hot_swap_sequence_fault_logic_tb;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic gateOn, fault_n, atMargin, drainHigh, secOk, seat_n = 1, lowSup = 1, trip = 0, clr_n = 1;
    logic [2:0] le = 3'h7;
    logic [3:0] pg_n;
    logic hiSup = 0, mode = 0, over50 = 0, regOut, fuseOut;
    logic [3:0] uvSteps;
    int fail_count = 0, samples_checked = 0, cyc = 0, n;
    always #2 core_clk = ~core_clk;
    hot_swap_sequence_fault_logic #(.US_CYCLES(1), .HOLDOFF_US(50)) dut_u (.core_clk, .rst_n,
        .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .card_seat_1_n(seat_n), .card_seat_2_n(seat_n), .master_enable_thermal(~lowSup),
        .low_supply_compare(lowSup), .high_supply_compare(hiSup), .drain_above_ref(drainHigh),
        .gate_at_margin(atMargin), .shunt_over_50(trip | over50), .shunt_over_60(trip),
        .shunt_over_100(trip), .shunt_over_200(1'b0), .secondary_shutdown_n(secOk),
        .load_enable_a(le[2]), .load_enable_b(le[1]), .load_enable_c(le[0]),
        .breaker_mode(mode), .breaker_clear_n(clr_n), .fuse_stored(1'b0),
        .fet_gate_drive(gateOn), .gate_regulate(regOut), .power_good_stage1_n(pg_n[0]),
        .power_good_stage2_n(pg_n[1]), .power_good_stage3_n(pg_n[2]),
        .power_good_stage4_n(pg_n[3]), .fault_n, .sticky_breaker_fuse(fuseOut),
        .uv_hysteresis_steps(uvSteps));
    hot_swap_far_side far_u (.core_clk, .fet_gate_drive(gateOn), .gate_at_margin(atMargin),
        .drain_above_ref(drainHigh), .secondary_shutdown_n(secOk));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task wait_low(input int k);
        n = -1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pg_n[k] !== 1'b0);
    endtask : wait_low
    task test_regs();
        apb(0, hot_swap_pkg::ADDR_CONFIG, 0);
        chk(rd, {8'h00, hot_swap_pkg::CONFIG_RESET});
        apb(0, 8'h08, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1, hot_swap_pkg::ADDR_CONFIG, 32'h1830);
        $display("test_regs done");
    endtask : test_regs
    task test_up();
        seat_n <= 0;
        lowSup <= 0;
        wait_low(0);
        chk({n > 500, gateOn, drainHigh}, 3'h6);
        chk(uvSteps, 4'h3);
        for (int k = 1; k < 4; k++) begin
            wait_low(k);
            chk(n > 49 && n < 54, 1);
        end
        $display("test_up done");
    endtask : test_up
    // Dropping C, then B, then A switches off later stages
    task test_le();
        for (int i = 0; i < 3; i++) begin
            le <= 3'h7 << (i + 1);
            repeat (6) @(posedge core_clk);
            chk({pg_n[1], pg_n[2], pg_n[3]}, {29'h0, ~le});
        end
        le <= 3'h7;
        $display("test_le done");
    endtask : test_le
    // Latched breaker stays off until the clear pulse
    task test_trip();
        trip <= 1;
        repeat (6) @(posedge core_clk);
        trip <= 0;
        chk({fault_n, gateOn, pg_n}, 6'h0f);
        repeat (300) @(posedge core_clk);
        chk(fault_n, 0);
        clr_n <= 0;
        repeat (4) @(posedge core_clk);
        clr_n <= 1;
        wait_low(0);
        chk({fault_n, n > 500}, 2'h3);
        $display("test_trip done");
    endtask : test_trip
    // High supply fault, regulation band, then a fuse that only a config write clears
    task test_faults();
        hiSup <= 1;
        repeat (6) @(posedge core_clk);
        hiSup <= 0;
        chk({fault_n, gateOn, pg_n[0]}, 3'h5);
        wait_low(0);
        apb(1, hot_swap_pkg::ADDR_CONFIG, 32'h1930);
        over50 <= 1;
        repeat (6) @(posedge core_clk);
        over50 <= 0;
        chk({regOut, gateOn, pg_n[0]}, 3'h6);
        repeat (6) @(posedge core_clk);
        chk({regOut, gateOn, pg_n[0]}, 3'h2);
        apb(1, hot_swap_pkg::ADDR_CONFIG, 32'h801830);
        {mode, trip} <= 2'h3;
        repeat (6) @(posedge core_clk);
        trip <= 0;
        chk({fuseOut, fault_n, gateOn}, 3'h4);
        clr_n <= 0;
        repeat (4) @(posedge core_clk);
        clr_n <= 1;
        repeat (8) @(posedge core_clk);
        chk({fuseOut, fault_n, pg_n[0]}, 3'h5);
        apb(1, hot_swap_pkg::ADDR_CONFIG, 32'h1830);
        repeat (2) @(posedge core_clk);
        chk({fuseOut, fault_n}, 2'h1);
        $display("test_faults done");
    endtask : test_faults
    task tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        test_regs();
        test_up();
        test_le();
        test_trip();
        test_faults();
        tally_and_finish();
    end
    // Whole run needs about 2100 cycles
    always @(posedge core_clk) if (++cyc == 20000) begin
        fail_count++;
        tally_and_finish();
    end
endmodule : hot_swap_sequence_fault_logic_tb
